// ===== verilog/iepc_core.sv
/*
 interrupt enable, two-level priority, external edge control and request
 arbitration for a small microcontroller core.
 assumes the core answers a request with a one-cycle ack pulse naming
 irq_num_o, and pulses reti at the end of each service routine.
*/
`timescale 1ns/1ps
`include "iepc_regs.svh"

module iepc_core (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire iepc_pkg::iepc_byte_t addr_i,
	input wire iepc_pkg::iepc_byte_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output iepc_pkg::iepc_byte_t rdata_o,
	input wire logic [3:0] ext0_line_i,
	input wire logic [7:0] ext1_line_i,
	input wire logic [3:0] ext2_line_i,
	input wire logic timer0_flag_i,
	input wire logic timer1_flag_i,
	input wire logic uart_flag_i,
	input wire logic timer2_flag_i,
	input wire logic adc_flag_i,
	input wire logic ssi_flag_i,
	input wire logic pwm_flag_i,
	input wire logic btm_flag_i,
	input wire logic cmp_flag_i,
	output logic irq_req_o,
	output iepc_pkg::iepc_num_t irq_num_o,
	output logic irq_high_o,
	input wire logic ack_i,
	input wire logic reti_i,
	output iepc_pkg::iepc_vec_t vec_ack_o
);
	import iepc_pkg::*;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic iepc_num_t first_set(input iepc_vec_t v);
		iepc_num_t n;
		n = 4'h0;
		for (int i = int'(IEPC_SRC_COUNT) - 1; i >= 0; i--) begin
			if (v[i]) begin
				n = 4'(i);
			end
		end
		return n;
	endfunction

	function automatic logic edge_hit(input logic [7:0] rise, input logic [7:0] fall,
		input iepc_byte_t ren, input iepc_byte_t fen);
		return |((rise & ren) | (fall & fen));
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	iepc_byte_t ie;
	iepc_byte_t ie2;
	iepc_byte_t ip;
	iepc_byte_t ip2;
	iepc_byte_t g0f;
	iepc_byte_t g0r;
	iepc_byte_t g1f;
	iepc_byte_t g1r;
	iepc_byte_t g2f;
	iepc_byte_t g2r;
	logic ext0_flag;
	logic ext1_flag;
	logic ext2_pend;
	logic svc_low;
	logic svc_high;

	logic [15:0] sync1;
	logic [15:0] sync2;
	logic [15:0] prev;
	logic [2:0] armed;

	logic [15:0] rise;
	logic [15:0] fall;
	logic ext0_evt;
	logic ext1_evt;
	logic ext2_evt;
	iepc_vec_t flags;
	iepc_vec_t enables;
	iepc_vec_t levels;
	iepc_vec_t pend;
	iepc_vec_t pend_hi;
	iepc_vec_t pend_lo;
	logic next_req;
	logic next_high;
	iepc_num_t next_num;
	iepc_byte_t next_rdata;
	logic ack_ext0;
	logic ack_ext1;
	logic ack_ext2;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ie <= `IEPC_RST_BYTE;
			ie2 <= `IEPC_RST_BYTE;
			ip <= `IEPC_RST_BYTE;
			ip2 <= `IEPC_RST_BYTE;
			g0f <= `IEPC_RST_BYTE;
			g0r <= `IEPC_RST_BYTE;
			g1f <= `IEPC_RST_BYTE;
			g1r <= `IEPC_RST_BYTE;
			g2f <= `IEPC_RST_BYTE;
			g2r <= `IEPC_RST_BYTE;
		end else if (wr_i) begin
			if (addr_i == `IEPC_OFS_IE) begin
				ie <= wdata_i & `IEPC_MSK_IE;
			end else if (addr_i == `IEPC_OFS_IE2) begin
				ie2 <= wdata_i & `IEPC_MSK_IE2;
			end else if (addr_i == `IEPC_OFS_IP) begin
				ip <= wdata_i & `IEPC_MSK_IP;
			end else if (addr_i == `IEPC_OFS_IP2) begin
				ip2 <= wdata_i & `IEPC_MSK_IE2;
			end else if (addr_i == `IEPC_OFS_G0F) begin
				g0f <= wdata_i & `IEPC_MSK_G0;
			end else if (addr_i == `IEPC_OFS_G0R) begin
				g0r <= wdata_i & `IEPC_MSK_G0;
			end else if (addr_i == `IEPC_OFS_G1F) begin
				g1f <= wdata_i & `IEPC_MSK_G1;
			end else if (addr_i == `IEPC_OFS_G1R) begin
				g1r <= wdata_i & `IEPC_MSK_G1;
			end else if (addr_i == `IEPC_OFS_G2F) begin
				g2f <= wdata_i & `IEPC_MSK_G2;
			end else if (addr_i == `IEPC_OFS_G2R) begin
				g2r <= wdata_i & `IEPC_MSK_G2;
			end
		end
	end

	// ----------------------------------------
	// line synchroniser and edge detect
	// ----------------------------------------
	// bit layout: 3:0 group 0 lines 4..7, 11:4 group 1, 15:12 group 2
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1 <= 16'h0000;
			sync2 <= 16'h0000;
			prev <= 16'h0000;
			armed <= 3'h0;
		end else begin
			sync1 <= {ext2_line_i, ext1_line_i, ext0_line_i};
			sync2 <= sync1;
			prev <= sync2;
			armed <= {armed[1:0], 1'b1};
		end
	end

	// edges are ignored until prev holds a real pin sample, so a line that
	// idles high gives no false edge against the reset value
	assign rise = armed[2] ? (sync2 & ~prev) : 16'h0000;
	assign fall = armed[2] ? (~sync2 & prev) : 16'h0000;
	assign ext0_evt = edge_hit({rise[3:0], 4'h0}, {fall[3:0], 4'h0}, g0r, g0f);
	assign ext1_evt = edge_hit(rise[11:4], fall[11:4], g1r, g1f);
	assign ext2_evt = edge_hit({4'h0, rise[15:12]}, {4'h0, fall[15:12]}, g2r, g2f);

	// ----------------------------------------
	// external request flags
	// ----------------------------------------
	assign ack_ext0 = ack_i && irq_req_o && irq_num_o == 4'(IEPC_SRC_EXT0);
	assign ack_ext1 = ack_i && irq_req_o && irq_num_o == 4'(IEPC_SRC_EXT1);
	assign ack_ext2 = ack_i && irq_req_o && irq_num_o == 4'(IEPC_SRC_EXT2);

	// a fresh edge beats the vectoring clear so no event is lost
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext0_flag <= 1'b0;
			ext1_flag <= 1'b0;
			ext2_pend <= 1'b0;
		end else begin
			if (ext0_evt) begin
				ext0_flag <= 1'b1;
			end else if (ack_ext0) begin
				ext0_flag <= 1'b0;
			end else if (wr_i && addr_i == `IEPC_OFS_TIMER_CONTROL_AND_EXT_FLAGS) begin
				ext0_flag <= wdata_i[`IEPC_BIT_EXT0_FLAG];
			end
			if (ext1_evt) begin
				ext1_flag <= 1'b1;
			end else if (ack_ext1) begin
				ext1_flag <= 1'b0;
			end else if (wr_i && addr_i == `IEPC_OFS_TIMER_CONTROL_AND_EXT_FLAGS) begin
				ext1_flag <= wdata_i[`IEPC_BIT_EXT1_FLAG];
			end
			if (ext2_evt) begin
				ext2_pend <= 1'b1;
			end else if (ack_ext2) begin
				ext2_pend <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// arbitration
	// ----------------------------------------
	assign flags = {cmp_flag_i, ext2_pend, btm_flag_i, pwm_flag_i, ssi_flag_i, adc_flag_i,
		timer2_flag_i, uart_flag_i, timer1_flag_i, ext1_flag, timer0_flag_i, ext0_flag};
	// modulator overflow is the pwm flag, gated by its own enable
	assign enables = {ie2[5], ie2[3], ie2[2], ie2[1], ie2[0], ie[6:0]};
	assign levels = {ip2[5], ip2[3], ip2[2], ip2[1], ip2[0], ip[6:0]};
	assign pend = ie[`IEPC_BIT_GLOBAL] ? (flags & enables) : 12'h000;
	assign pend_hi = pend & levels;
	assign pend_lo = pend & ~levels;

	always_comb begin
		next_req = 1'b0;
		next_high = 1'b0;
		next_num = 4'h0;
		if (!svc_high && pend_hi != 12'h000) begin
			next_req = 1'b1;
			next_high = 1'b1;
			next_num = first_set(pend_hi);
		end else if (!svc_high && !svc_low && pend_lo != 12'h000) begin
			next_req = 1'b1;
			next_num = first_set(pend_lo);
		end
	end

	// request is re-evaluated each cycle; an unserved source keeps asking
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_req_o <= 1'b0;
			irq_high_o <= 1'b0;
			irq_num_o <= 4'h0;
		end else begin
			irq_req_o <= next_req && !ack_i;
			irq_high_o <= next_high;
			irq_num_o <= next_num;
		end
	end

	// ----------------------------------------
	// service level tracking
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			svc_low <= 1'b0;
			svc_high <= 1'b0;
		end else if (ack_i && irq_req_o) begin
			if (irq_high_o) begin
				svc_high <= 1'b1;
			end else begin
				svc_low <= 1'b1;
			end
		end else if (reti_i) begin
			if (svc_high) begin
				svc_high <= 1'b0;
			end else begin
				svc_low <= 1'b0;
			end
		end
	end

	// hardware-cleared peripheral flags use this strobe
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vec_ack_o <= 12'h000;
		end else if (ack_i && irq_req_o) begin
			vec_ack_o <= 12'h001 << irq_num_o;
		end else begin
			vec_ack_o <= 12'h000;
		end
	end

	// ----------------------------------------
	// register reads
	// ----------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		if (addr_i == `IEPC_OFS_IE) begin
			next_rdata = ie;
		end else if (addr_i == `IEPC_OFS_IE2) begin
			next_rdata = ie2;
		end else if (addr_i == `IEPC_OFS_IP) begin
			next_rdata = ip;
		end else if (addr_i == `IEPC_OFS_IP2) begin
			next_rdata = ip2;
		end else if (addr_i == `IEPC_OFS_TIMER_CONTROL_AND_EXT_FLAGS) begin
			next_rdata = {4'h0, ext1_flag, 1'b0, ext0_flag, 1'b0};
		end else if (addr_i == `IEPC_OFS_G0F) begin
			next_rdata = g0f;
		end else if (addr_i == `IEPC_OFS_G0R) begin
			next_rdata = g0r;
		end else if (addr_i == `IEPC_OFS_G1F) begin
			next_rdata = g1f;
		end else if (addr_i == `IEPC_OFS_G1R) begin
			next_rdata = g1r;
		end else if (addr_i == `IEPC_OFS_G2F) begin
			next_rdata = g2f;
		end else if (addr_i == `IEPC_OFS_G2R) begin
			next_rdata = g2r;
		end
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence ack_of_ext0;
		ack_i && irq_req_o && irq_num_o == 4'h0 && !ext0_evt;
	endsequence

	sequence edge_of_ext1;
		ext1_evt ##1 ext1_flag;
	endsequence

	global_gate_a: assert property (!ie[7] |=> !irq_req_o)
		else $error("request raised while global enable off");

	pwm_gate_a: assert property (ie[7] && !ie2[1] |=> !(irq_req_o && irq_num_o == 4'h8))
		else $error("modulator request while its enable is off");

	ext0_set_a: assert property (ext0_evt |=> ext0_flag)
		else $error("group 0 flag not set by qualified edge");

	ext1_set_a: assert property (ext1_evt |-> edge_of_ext1)
		else $error("group 1 flag not set by qualified edge");

	flag_clear_a: assert property (ack_of_ext0 |=> !ext0_flag ##1 vec_ack_o == 12'h000)
		else $error("group 0 flag kept after vectoring");

	high_block_a: assert property (svc_high |=> !irq_req_o)
		else $error("request while high level in service");

	low_wait_a: assert property (irq_req_o && !irq_high_o |-> $past(!svc_low && !svc_high))
		else $error("low request during a running service");

	query_order_a: assert property (irq_req_o |->
		(((irq_high_o ? $past(pend_hi) : $past(pend_lo)) & ((12'h001 << irq_num_o) - 12'h001)) == 12'h000))
		else $error("larger query number served first");

	pend_hold_a: assert property (ie[7] && ie[0] && ext0_flag && !svc_high && !svc_low
		&& !ack_i |=> irq_req_o)
		else $error("pending group 0 request not raised");

	dual_edge_a: assert property (armed[2] && g1r[0] && g1f[0] && sync2[4] != prev[4] |=> ext1_flag)
		else $error("dual edge did not set group 1 flag");

	sync_edge_a: assert property (sync2 == prev |-> !ext0_evt && !ext1_evt && !ext2_evt)
		else $error("edge seen without sample change");

	reserved_read_a: assert property (rd_i && addr_i == 8'h88 |=> (rdata_o & 8'hf5) == 8'h00)
		else $error("reserved flag bits read non-zero");

endmodule

// ===== verilog/iepc_regs.svh
/*
 register offsets, writable masks, reset values and bit positions of the
 interrupt enable, priority and edge control block.
 assumes an 8-bit register port with byte-wide offsets.
*/
`ifndef IEPC_REGS_SVH
`define IEPC_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define IEPC_OFS_TIMER_CONTROL_AND_EXT_FLAGS 8'h88
`define IEPC_OFS_IE 8'ha8
`define IEPC_OFS_IE2 8'ha9
`define IEPC_OFS_IP 8'hb8
`define IEPC_OFS_IP2 8'hb9
`define IEPC_OFS_G0F 8'hba
`define IEPC_OFS_G0R 8'hbb
`define IEPC_OFS_G1F 8'hbc
`define IEPC_OFS_G1R 8'hbd
`define IEPC_OFS_G2F 8'hc6
`define IEPC_OFS_G2R 8'hc7

// ----------------------------------------
// implemented bits, reserved bits read zero
// ----------------------------------------
`define IEPC_MSK_IE 8'hff
`define IEPC_MSK_IE2 8'h2f
`define IEPC_MSK_IP 8'h7f
`define IEPC_MSK_TIMER_CONTROL_AND_EXT_FLAGS 8'h0a
`define IEPC_MSK_G0 8'hf0
`define IEPC_MSK_G1 8'hff
`define IEPC_MSK_G2 8'h0f
`define IEPC_RST_BYTE 8'h00

// ----------------------------------------
// bit positions
// ----------------------------------------
`define IEPC_BIT_GLOBAL 7
`define IEPC_BIT_EXT1_FLAG 3
`define IEPC_BIT_EXT0_FLAG 1

`endif

// ===== verilog/iepc_pkg.sv
/*
 types shared by the interrupt enable, priority and edge control block.
 assumes the constants header is included where offsets are needed.
*/
package iepc_pkg;

	// sources in query order, the first served first at equal level
	typedef enum {
		IEPC_SRC_EXT0,
		IEPC_SRC_TIMER0,
		IEPC_SRC_EXT1,
		IEPC_SRC_TIMER1,
		IEPC_SRC_UART,
		IEPC_SRC_TIMER2,
		IEPC_SRC_ADC,
		IEPC_SRC_SSI,
		IEPC_SRC_PWM,
		IEPC_SRC_BTM,
		IEPC_SRC_EXT2,
		IEPC_SRC_CMP,
		IEPC_SRC_COUNT
	} iepc_src_e;

	typedef logic [7:0] iepc_byte_t;
	typedef logic [3:0] iepc_num_t;
	typedef logic [11:0] iepc_vec_t;

endpackage

// ===== testbench/iepc_core_model.sv
/*
 behavioural processor core facing the interrupt block: vectors to a
 standing request when allowed, and returns from routines on command.
 assumes the request output is registered and that an ack is counted
 only while the request stands.
*/
`timescale 1ns/1ps
module iepc_core_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic irq_req_i,
	input wire logic take_i,
	input wire logic ret_i,
	output logic ack_o,
	output logic reti_o
);
	// ----------------------------------------
	// vectoring and return
	// ----------------------------------------
	// take_i low makes the core slow: a request may stand for many cycles
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o <= 1'b0;
			reti_o <= 1'b0;
		end else begin
			ack_o <= take_i && irq_req_i && !ack_o;
			reti_o <= ret_i;
		end
	end
endmodule

// ===== testbench/tb.sv
/*
 self-checking bench for the interrupt enable, priority and edge block.
 assumes a 50 mhz clock, a one-cycle read latency and a core model that
 acks only while take is high.
*/
`timescale 1ns/1ps
module tb;
	import iepc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	iepc_byte_t addr = 8'h00;
	iepc_byte_t wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	iepc_byte_t rdata_o;
	logic [3:0] ln0 = 4'h0;
	logic [7:0] ln1 = 8'h00;
	logic [3:0] ln2 = 4'h0;
	logic [8:0] pf = 9'h000;
	logic irq_req_o;
	iepc_num_t irq_num_o;
	logic irq_high_o;
	iepc_vec_t vec_ack_o;
	logic ack;
	logic reti;
	logic take = 1'b0;
	logic rc = 1'b0;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int i;
	int h;
	iepc_byte_t offs [12] = '{8'h88, 8'ha8, 8'ha9, 8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hc6, 8'hc7, 8'h89};
	iepc_byte_t msk [12] = '{8'h0a, 8'hff, 8'h2f, 8'h7f, 8'h2f, 8'hf0, 8'hf0, 8'hff, 8'hff, 8'h0f, 8'h0f, 8'h00};
	iepc_byte_t iev [9] = '{8'h02, 8'h08, 8'h10, 8'h20, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
	iepc_byte_t ie2v [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h04, 8'h20};
	int nums [9] = '{1, 3, 4, 5, 6, 7, 8, 9, 11};

	always #10 clk_i = ~clk_i;

	iepc_core i_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata_o), .ext0_line_i(ln0), .ext1_line_i(ln1), .ext2_line_i(ln2),
		.timer0_flag_i(pf[0]), .timer1_flag_i(pf[1]), .uart_flag_i(pf[2]), .timer2_flag_i(pf[3]),
		.adc_flag_i(pf[4]), .ssi_flag_i(pf[5]), .pwm_flag_i(pf[6]), .btm_flag_i(pf[7]),
		.cmp_flag_i(pf[8]), .irq_req_o(irq_req_o), .irq_num_o(irq_num_o), .irq_high_o(irq_high_o),
		.ack_i(ack), .reti_i(reti), .vec_ack_o(vec_ack_o)
	);

	iepc_core_model i_core (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_req_i(irq_req_o), .take_i(take), .ret_i(rc),
		.ack_o(ack), .reti_o(reti)
	);

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// a hang in any wait loop ends here
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			results();
		end
	end

	// ----------------------------------------
	// register port and core link tasks
	// ----------------------------------------
	task automatic wr_reg(input iepc_byte_t a, input iepc_byte_t d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input iepc_byte_t a, input iepc_byte_t exp);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		check(rdata_o, exp);
	endtask

	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge clk_i);
			#1;
			check(irq_req_o, 12'h000);
		end
	endtask

	// request must stand with the right number and level, then vector
	task automatic serve(input int n, input logic hi);
		int k;
		k = 0;
		@(posedge clk_i);
		#1;
		while (irq_req_o !== 1'b1 && k < 40) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		check(irq_req_o, 12'h001);
		check(irq_num_o, n[11:0]);
		check(irq_high_o, {11'h000, hi});
		@(posedge clk_i);
		take <= 1'b1;
		k = 0;
		while (vec_ack_o === 12'h000 && k < 10) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		check(vec_ack_o, 12'h001 << n);
		@(posedge clk_i);
		take <= 1'b0;
	endtask

	task automatic ret();
		@(posedge clk_i);
		rc <= 1'b1;
		@(posedge clk_i);
		rc <= 1'b0;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		for (i = 0; i < 12; i++) rd_reg(offs[i], 8'h00);
		for (i = 0; i < 12; i++) wr_reg(offs[i], 8'hff);
		for (i = 0; i < 12; i++) rd_reg(offs[i], msk[i]);
		for (i = 0; i < 12; i++) wr_reg(offs[i], 8'h00);
		quiet(4);
		// global and own enable gating with a held modulator overflow
		@(posedge clk_i) pf[6] <= 1'b1;
		wr_reg(8'ha8, 8'h80);
		quiet(6);
		wr_reg(8'ha9, 8'h02);
		wr_reg(8'ha8, 8'h00);
		quiet(6);
		wr_reg(8'ha8, 8'h80);
		serve(8, 1'b0);
		@(posedge clk_i) pf[6] <= 1'b0;
		ret();
		// every peripheral source at both levels
		for (h = 0; h < 2; h++) begin
			for (i = 0; i < 9; i++) begin
				wr_reg(8'ha8, 8'h80 | iev[i]);
				wr_reg(8'ha9, ie2v[i]);
				wr_reg(8'hb8, (h == 1) ? iev[i] : 8'h00);
				wr_reg(8'hb9, (h == 1) ? ie2v[i] : 8'h00);
				@(posedge clk_i) pf[i] <= 1'b1;
				serve(nums[i], h[0]);
				@(posedge clk_i) pf[i] <= 1'b0;
				ret();
			end
		end
		wr_reg(8'hb8, 8'h00);
		wr_reg(8'hb9, 8'h00);
		wr_reg(8'ha9, 8'h00);
		// equal level order, low waits, high preempts
		wr_reg(8'ha8, 8'h92);
		@(posedge clk_i) pf <= 9'h005;
		serve(1, 1'b0);
		@(posedge clk_i) pf[0] <= 1'b0;
		quiet(6);
		wr_reg(8'hb8, 8'h10);
		serve(4, 1'b1);
		@(posedge clk_i) pf[2] <= 1'b0;
		ret();
		ret();
		wr_reg(8'hb8, 8'h00);
		// group 0: falling enabled on line 4, then rising on line 5
		wr_reg(8'ha8, 8'h00);
		wr_reg(8'hba, 8'h10);
		@(posedge clk_i) ln0 <= 4'h1;
		repeat (6) @(posedge clk_i);
		rd_reg(8'h88, 8'h00);
		@(posedge clk_i) ln0 <= 4'h0;
		repeat (6) @(posedge clk_i);
		rd_reg(8'h88, 8'h02);
		wr_reg(8'hbb, 8'h20);
		wr_reg(8'ha8, 8'h81);
		serve(0, 1'b0);
		rd_reg(8'h88, 8'h00);
		ret();
		@(posedge clk_i) ln0 <= 4'h2;
		serve(0, 1'b0);
		ret();
		// group 1: rising on line 7, falling on line 0, then dual on line 0
		wr_reg(8'hbc, 8'h01);
		wr_reg(8'hbd, 8'h80);
		wr_reg(8'ha8, 8'h84);
		@(posedge clk_i) ln1 <= 8'h81;
		serve(2, 1'b0);
		rd_reg(8'h88, 8'h00);
		ret();
		@(posedge clk_i) ln1 <= 8'h01;
		quiet(6);
		@(posedge clk_i) ln1 <= 8'h00;
		serve(2, 1'b0);
		ret();
		wr_reg(8'hbd, 8'h01);
		@(posedge clk_i) ln1 <= 8'h01;
		serve(2, 1'b0);
		ret();
		@(posedge clk_i) ln1 <= 8'h00;
		serve(2, 1'b0);
		ret();
		// group 2: falling on line 0, rising on line 3
		wr_reg(8'ha8, 8'h80);
		wr_reg(8'ha9, 8'h08);
		wr_reg(8'hc6, 8'h01);
		wr_reg(8'hc7, 8'h08);
		@(posedge clk_i) ln2 <= 4'h1;
		quiet(6);
		@(posedge clk_i) ln2 <= 4'h9;
		serve(10, 1'b0);
		ret();
		@(posedge clk_i) ln2 <= 4'h8;
		serve(10, 1'b0);
		ret();
		@(posedge clk_i) ln2 <= 4'h0;
		quiet(6);
		results();
	end
endmodule
